//--- src/eeprom_device.sv
// Serial EEPROM device end: decode, write protection and timed programming
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Start bit, two-bit op-code, eight-bit address
// [R2] Top address bit ignored for memory
// [R3] Programming needs write-enable latch set
// [R4] Reset clears latch; only disable clears
// [R5] Host should disable writes after programming
// [R6] Reads ignore the write-enable latch
// [R7] Host holds write pin high
// [R8] Chip-select fall starts unprotected programming
// [R9] Busy drives output low, input ignored
// [R10] Ready high until start or deselect
// [R11] Page write carries one to four words
// [R12] Page address wraps in low bits
// [R13] Any protected page word abandons all
// [R14] Write-all only with cleared protection
// [R15] Protect write sets boundary, flag zero
// [R16] Unlock must immediately precede protect ops
// [R17] Unlock needs latch and pins, keeps flag
// [R18] Protect read: dummy, register, flag
// [R19] Protect clear: all ones, flag one
// [R20] Lock bit freezes protect register
// [R21] Locked protect write shows no busy
// [R22] Host judges protection by busy seen on poll
// [R23] Counter times programming, commits at end
module eeprom_device #(
  parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  eeprom_link_if.dev link,
  output logic       progBusy
);

  if (PROG_CYCLES < 1) begin : gBadCycles
    $error("PROG_CYCLES must be at least one");
  end

  localparam int unsigned AW    = eeprom_pkg::ADDR_W;
  localparam int unsigned DW    = eeprom_pkg::DATA_W;
  localparam int unsigned WORDS = 2 ** (AW - 1);

  typedef enum logic [2:0] {
    ST_START, ST_OPC, ST_ADDR, ST_DATA, ST_END, ST_READ, ST_IGNORE, ST_BUSY
  } state_t;
  typedef enum logic [2:0] {
    PD_NONE, PD_WORD, PD_PAGE, PD_ALL, PD_PWRITE, PD_PCLEAR, PD_PLOCK
  } pend_t;

  logic [4:0]    pinMeta_q;
  logic [4:0]    pinSync_q;
  logic [4:0]    pinPrev_q;
  logic          csHi;
  logic          csFall;
  logic          sclkRise;
  logic          dinS;
  logic          wS;
  logic          preS;
  state_t        state_q;
  pend_t         pend_q;
  logic [4:0]    bitCnt_q;
  logic [1:0]    opc_q;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] addrNext;
  logic [DW-1:0] shiftIn_q;
  logic [DW-1:0] wordNext;
  logic [DW-1:0] outShift_q;
  logic [DW-1:0] mem [WORDS];
  logic [DW-1:0] pageBuf_q [eeprom_pkg::PAGE_WORDS];
  logic [3:0]    pageMask_q;
  logic [1:0]    wordCnt_q;
  logic          wordDone_q;
  logic          protRead_q;
  logic          weLatch_q;
  logic          unlock_q;
  logic          guardOk;
  logic          otp_q;
  logic          protFlag_q;
  logic [AW-1:0] protReg_q;
  logic [31:0]   progCnt_q;
  logic          progDone;
  logic          commitOk;
  logic          readyShow_q;
  logic          dout_q;
  logic          doutEn_q;

  // True when protection is cleared or a word address lies below the protected boundary
  function automatic logic protOk(input logic [AW-2:0] a, input logic flag,
                                  input logic [AW-1:0] bound);
    protOk = flag || (a < bound[AW-2:0]);
  endfunction : protOk

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinPrev_q <= '0;
    end else begin
      pinMeta_q <= {link.cs, link.sclk, link.din, link.writeEnPin, link.protEnPin};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  assign csHi     = pinSync_q[4];
  assign csFall   = pinPrev_q[4] && !pinSync_q[4];
  assign sclkRise = pinSync_q[3] && !pinPrev_q[3];
  assign dinS     = pinSync_q[2];
  assign wS       = pinSync_q[1];
  assign preS     = pinSync_q[0];
  assign addrNext = {addr_q[AW-2:0], dinS};
  assign wordNext = {shiftIn_q[DW-2:0], dinS};
  assign guardOk  = weLatch_q && wS && unlock_q; // R16 R17
  assign progDone = (state_q == ST_BUSY) && (progCnt_q == '0);

  always_comb begin
    unique case (pend_q)
      PD_WORD:   commitOk = protOk(addr_q[AW-2:0], protFlag_q, protReg_q); // R8
      PD_PAGE:   commitOk = wordDone_q
                            && protOk({addr_q[AW-2:2], 2'h3}, protFlag_q, protReg_q); // R13
      PD_ALL:    commitOk = protFlag_q; // R14
      PD_PWRITE, PD_PCLEAR, PD_PLOCK: commitOk = !otp_q; // R20 R21
      default:   commitOk = 1'h0;
    endcase
  end

  // ****************************************
  // Instruction sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q    <= ST_START;
      pend_q     <= PD_NONE;
      bitCnt_q   <= '0;
      opc_q      <= '0;
      addr_q     <= '0;
      shiftIn_q  <= '0;
      outShift_q <= '0;
      pageMask_q <= '0;
      wordCnt_q  <= '0;
      wordDone_q <= 1'h0;
      protRead_q <= 1'h0;
      weLatch_q  <= 1'h0; // R4
      unlock_q   <= 1'h0;
      for (int i = 0; i < eeprom_pkg::PAGE_WORDS; i++) pageBuf_q[i] <= '0;
    end else if (state_q == ST_BUSY) begin
      if (progDone) // R9
        state_q <= ST_START;
    end else if (csFall) begin
      if ((state_q == ST_END || (state_q == ST_DATA && pend_q == PD_PAGE)) && commitOk)
        state_q <= ST_BUSY; // R8
      else
        state_q <= ST_START;
    end else if (csHi && sclkRise) begin
      unique case (state_q)
        ST_START:
          if (dinS) // R1
          begin
            state_q  <= ST_OPC;
            bitCnt_q <= '0;
          end
        ST_OPC:
        begin
          opc_q    <= {opc_q[0], dinS};
          bitCnt_q <= bitCnt_q + 5'h01;
          if (bitCnt_q == 5'h01)
          begin
            state_q  <= ST_ADDR;
            bitCnt_q <= '0;
          end
        end
        ST_ADDR:
        begin
          addr_q   <= addrNext;
          bitCnt_q <= bitCnt_q + 5'h01;
          if (bitCnt_q == 5'h07) // R1
          begin
            bitCnt_q   <= '0;
            pageMask_q <= '0;
            wordCnt_q  <= '0;
            wordDone_q <= 1'h0;
            unlock_q   <= 1'h0; // R16
            state_q    <= ST_IGNORE;
            pend_q     <= PD_NONE;
            unique case ({preS, opc_q})
              {1'h0, eeprom_pkg::OP_READ}, {1'h1, eeprom_pkg::OP_READ}:
              begin
                state_q    <= ST_READ; // R6
                protRead_q <= preS;
                outShift_q <= preS ? {protReg_q, protFlag_q, 7'h00} // R18
                                   : mem[addrNext[AW-2:0]]; // R2
              end
              {1'h0, eeprom_pkg::OP_WRITE}:
                if (weLatch_q && wS) // R3
                begin
                  state_q <= ST_DATA;
                  pend_q  <= PD_WORD;
                end
              {1'h0, eeprom_pkg::OP_PAGE}:
                if (weLatch_q && wS) // R3
                begin
                  state_q <= ST_DATA;
                  pend_q  <= PD_PAGE;
                end
              {1'h0, eeprom_pkg::OP_MISC}:
                unique case (addrNext[AW-1:AW-2])
                  eeprom_pkg::SUB_WRITE_ALL_CMD:
                    if (weLatch_q && wS && protFlag_q) // R14
                    begin
                      state_q <= ST_DATA;
                      pend_q  <= PD_ALL;
                    end
                  eeprom_pkg::SUB_WEN: if (wS) weLatch_q <= 1'h1;
                  eeprom_pkg::SUB_WDS: weLatch_q <= 1'h0; // R4
                  default: ;
                endcase
              {1'h1, eeprom_pkg::OP_WRITE}:
                if (guardOk)
                begin
                  state_q <= ST_END;
                  pend_q  <= PD_PWRITE;
                end
              {1'h1, eeprom_pkg::OP_PAGE}:
                if (guardOk && addrNext[AW-2:0] == eeprom_pkg::ADDR_PCLEAR[AW-2:0])
                begin
                  state_q <= ST_END;
                  pend_q  <= PD_PCLEAR;
                end
              {1'h1, eeprom_pkg::OP_MISC}:
                if (addrNext[AW-1:AW-2] == eeprom_pkg::SUB_WEN && weLatch_q && wS)
                  unlock_q <= 1'h1; // R17
                else if (guardOk && addrNext[AW-2:0] == eeprom_pkg::ADDR_WDS[AW-2:0])
                begin
                  state_q <= ST_END;
                  pend_q  <= PD_PLOCK;
                end
              default: ;
            endcase
          end
        end
        ST_DATA:
        begin
          shiftIn_q  <= wordNext;
          bitCnt_q   <= bitCnt_q + 5'h01;
          wordDone_q <= 1'h0;
          if (bitCnt_q == 5'h0F)
          begin
            bitCnt_q   <= '0;
            wordDone_q <= 1'h1;
            if (pend_q == PD_PAGE)
            begin
              pageBuf_q[addr_q[1:0]]  <= wordNext;
              pageMask_q[addr_q[1:0]] <= 1'h1;
              addr_q[1:0]             <= addr_q[1:0] + 2'h1; // R12
              wordCnt_q               <= wordCnt_q + 2'h1;
              if (wordCnt_q == 2'h3) // R11
                state_q <= ST_END;
            end else begin
              pageBuf_q[0] <= wordNext;
              state_q      <= ST_END;
            end
          end
        end
        ST_END:
        begin
          state_q <= ST_IGNORE; // R8
          pend_q  <= PD_NONE;
        end
        ST_READ:
        begin
          bitCnt_q   <= bitCnt_q + 5'h01;
          outShift_q <= {outShift_q[DW-2:0], 1'h0};
          if (bitCnt_q == 5'h0F && !protRead_q)
          begin
            bitCnt_q           <= '0;
            addr_q[AW-2:0]     <= addr_q[AW-2:0] + 7'h01;
            outShift_q         <= mem[addr_q[AW-2:0] + 7'h01];
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Programming timer and commit
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      progCnt_q <= '0;
    else if (state_q != ST_BUSY)
      progCnt_q <= PROG_CYCLES - 1; // R23
    else if (progCnt_q != '0)
      progCnt_q <= progCnt_q - 32'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < WORDS; i++) mem[i] <= eeprom_pkg::MEM_RESET;
      protReg_q  <= eeprom_pkg::PROT_RESET;
      protFlag_q <= 1'h1;
      otp_q      <= 1'h0;
    end else if (progDone) begin // R23
      unique case (pend_q)
        PD_WORD: mem[addr_q[AW-2:0]] <= pageBuf_q[0];
        PD_PAGE:
          for (int i = 0; i < eeprom_pkg::PAGE_WORDS; i++)
            if (pageMask_q[i]) mem[{addr_q[AW-2:2], 2'(i)}] <= pageBuf_q[i];
        PD_ALL: for (int i = 0; i < WORDS; i++) mem[i] <= pageBuf_q[0]; // R14
        PD_PWRITE:
        begin
          protReg_q  <= addr_q; // R15
          protFlag_q <= 1'h0;
        end
        PD_PCLEAR:
        begin
          protReg_q  <= eeprom_pkg::ADDR_PCLEAR; // R19
          protFlag_q <= 1'h1;
        end
        PD_PLOCK: otp_q <= 1'h1; // R20
        default: ;
      endcase
    end
  end

  // ****************************************
  // Data output and ready/busy
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      readyShow_q <= 1'h0;
    else if (progDone)
      readyShow_q <= 1'h1;
    else if (csFall || (state_q == ST_START && csHi && sclkRise && dinS))
      readyShow_q <= 1'h0; // R10
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dout_q   <= 1'h1;
      doutEn_q <= 1'h0;
      progBusy <= 1'h0;
    end else begin
      progBusy <= (state_q == ST_BUSY);
      doutEn_q <= csHi && (state_q == ST_BUSY || state_q == ST_READ || readyShow_q);
      if (state_q == ST_BUSY)
        dout_q <= 1'h0; // R9
      else if (readyShow_q)
        dout_q <= 1'h1; // R10
      else if (state_q == ST_ADDR)
        dout_q <= 1'h0;
      else if (state_q == ST_READ && sclkRise)
        dout_q <= outShift_q[DW-1];
    end
  end

  assign link.dout   = dout_q;
  assign link.doutEn = doutEn_q;

endmodule : eeprom_device

//--- src/eeprom_pkg.sv
// Shared constants and types for the serial EEPROM link
package eeprom_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned PAGE_WORDS = 4;
  localparam int unsigned HDR_BITS   = 11;
  localparam int unsigned FRAME_BITS = HDR_BITS + DATA_W * PAGE_WORDS;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned PROG_TIME_NS     = 10_000_000;
  localparam int unsigned PROG_CYCLES      = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SCLK_HALF_NS     = 500;
  localparam int unsigned SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CS_GAP_NS        = 250;
  localparam int unsigned CS_GAP_CYCLES    = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Op-codes and fixed address fields
  // ****************************************
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_PAGE     = 2'h3;
  localparam logic [1:0] OP_MISC     = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL_CMD   = 2'h1;
  localparam logic [1:0] SUB_WEN     = 2'h3;
  localparam logic [1:0] SUB_WDS     = 2'h0;
  localparam logic [7:0] ADDR_WRITE_ALL_CMD  = 8'h40;
  localparam logic [7:0] ADDR_WEN    = 8'hC0;
  localparam logic [7:0] ADDR_WDS    = 8'h00;
  localparam logic [7:0] ADDR_PCLEAR = 8'hFF;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  PROT_RESET = 8'hFF;
  localparam logic [15:0] MEM_RESET  = 16'hFFFF;

  typedef enum logic [3:0] {
    READ_CMD, WRITE_CMD, PAGE_WRITE_CMD, WRITE_ALL_CMD, WRITE_ENABLE_CMD,
    WRITE_DISABLE_CMD, PROTECT_READ_CMD, PROTECT_WRITE_CMD, PROTECT_CLEAR_CMD,
    PROTECT_UNLOCK_CMD, PROTECT_LOCK_CMD
  } cmd_t;

endpackage : eeprom_pkg

//--- src/eeprom_link_if.sv
// Three-wire serial link between host and EEPROM device
`timescale 1ns/1ps
interface eeprom_link_if;
  logic cs;
  logic sclk;
  logic din;
  logic writeEnPin;
  logic protEnPin;
  logic dout;
  logic doutEn;
  logic qLine;

  // Data output floats high when released
  assign qLine = doutEn ? dout : 1'h1;

  modport dev  (input cs, sclk, din, writeEnPin, protEnPin, output dout, doutEn);
  modport host (output cs, sclk, din, writeEnPin, protEnPin, input qLine);
endinterface : eeprom_link_if

//--- src/eeprom_host.sv
// Host end: frames instructions onto the serial link and polls ready
`timescale 1ns/1ps
module eeprom_host #(
  parameter int unsigned HALF_CYCLES = eeprom_pkg::SCLK_HALF_CYCLES,
  parameter int unsigned GAP_CYCLES  = eeprom_pkg::CS_GAP_CYCLES
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  eeprom_link_if.host       link,
  input  wire logic         cmdValid,
  input  eeprom_pkg::cmd_t  cmdOp,
  input  wire logic [7:0]   cmdAddr,
  input  wire logic [2:0]   cmdWords,
  input  wire logic [63:0]  cmdData,
  output logic              cmdReady,
  output logic              rspValid,
  output logic [15:0]       rspData,
  output logic              rspBusySeen
);

  if (HALF_CYCLES < 1 || HALF_CYCLES > 255 || GAP_CYCLES < 1 || GAP_CYCLES > 255)
  begin : gBadTiming
    $error("HALF_CYCLES and GAP_CYCLES must lie in 1..255");
  end

  localparam int unsigned FB = eeprom_pkg::FRAME_BITS;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_LOW, H_HIGH, H_TAIL, H_GAP, H_POLL, H_DONE
  } hstate_t;

  hstate_t       state_q;
  logic [FB-1:0] tx_q;
  logic [6:0]    txLen_q;
  logic [6:0]    totLen_q;
  logic [6:0]    bitCnt_q;
  logic [15:0]   rx_q;
  logic [7:0]    timer_q;
  logic          poll_q;
  logic          polled_q;
  logic          doutMeta_q;
  logic          doutSync_q;
  logic          cs_q;
  logic          sclk_q;
  logic          din_q;
  logic          wPin_q;
  logic          prePin_q;
  logic [1:0]    cOpc;
  logic [7:0]    cAddr;
  logic          cW;
  logic          cPre;
  logic          cData;
  logic          cPoll;
  logic [4:0]    cRx;
  logic [2:0]    nWords;

  // ****************************************
  // Command encoding
  // ****************************************
  always_comb begin
    cOpc   = eeprom_pkg::OP_MISC;
    cAddr  = cmdAddr;
    cW     = 1'h1;
    cPre   = 1'h0;
    cData  = 1'h0;
    cPoll  = 1'h0;
    cRx    = 5'h00;
    nWords = 3'h1;
    unique case (cmdOp)
      eeprom_pkg::READ_CMD:          begin cOpc = eeprom_pkg::OP_READ; cW = 1'h0; cRx = 5'h10; end
      eeprom_pkg::WRITE_CMD:         begin cOpc = eeprom_pkg::OP_WRITE; cData = 1'h1; cPoll = 1'h1; end
      eeprom_pkg::PAGE_WRITE_CMD:
      begin
        cOpc   = eeprom_pkg::OP_PAGE;
        cData  = 1'h1;
        cPoll  = 1'h1;
        nWords = cmdWords;
      end
      eeprom_pkg::WRITE_ALL_CMD:
      begin
        cAddr = eeprom_pkg::ADDR_WRITE_ALL_CMD;
        cData = 1'h1;
        cPoll = 1'h1;
      end
      eeprom_pkg::WRITE_ENABLE_CMD:  cAddr = eeprom_pkg::ADDR_WEN;
      eeprom_pkg::WRITE_DISABLE_CMD: begin cAddr = eeprom_pkg::ADDR_WDS; cW = 1'h0; end
      eeprom_pkg::PROTECT_READ_CMD:
      begin
        cOpc = eeprom_pkg::OP_READ;
        cW   = 1'h0;
        cPre = 1'h1;
        cRx  = 5'h09;
      end
      eeprom_pkg::PROTECT_WRITE_CMD: begin cOpc = eeprom_pkg::OP_WRITE; cPre = 1'h1; cPoll = 1'h1; end
      eeprom_pkg::PROTECT_CLEAR_CMD:
      begin
        cOpc  = eeprom_pkg::OP_PAGE;
        cAddr = eeprom_pkg::ADDR_PCLEAR;
        cPre  = 1'h1;
        cPoll = 1'h1;
      end
      eeprom_pkg::PROTECT_UNLOCK_CMD: begin cAddr = eeprom_pkg::ADDR_WEN; cPre = 1'h1; end
      eeprom_pkg::PROTECT_LOCK_CMD:
      begin
        cAddr = eeprom_pkg::ADDR_WDS;
        cPre  = 1'h1;
        cPoll = 1'h1;
      end
      default: ;
    endcase
  end

  // ****************************************
  // Ready line synchroniser
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      doutMeta_q <= 1'h1;
      doutSync_q <= 1'h1;
    end else begin
      doutMeta_q <= link.qLine;
      doutSync_q <= doutMeta_q;
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q     <= H_IDLE;
      tx_q        <= '0;
      txLen_q     <= '0;
      totLen_q    <= '0;
      bitCnt_q    <= '0;
      rx_q        <= '0;
      timer_q     <= '0;
      poll_q      <= 1'h0;
      polled_q    <= 1'h0;
      cs_q        <= 1'h0;
      sclk_q      <= 1'h0;
      din_q       <= 1'h0;
      wPin_q      <= 1'h0;
      prePin_q    <= 1'h0;
      cmdReady    <= 1'h0;
      rspValid    <= 1'h0;
      rspData     <= '0;
      rspBusySeen <= 1'h0;
    end else begin
      rspValid <= 1'h0;
      if (timer_q != '0) timer_q <= timer_q - 8'h01;
      unique case (state_q)
        H_IDLE:
        begin
          cmdReady <= 1'h1;
          if (cmdValid && cmdReady)
          begin
            cmdReady    <= 1'h0;
            tx_q        <= {1'h1, cOpc, cAddr, cmdData};
            txLen_q     <= 7'(eeprom_pkg::HDR_BITS + (cData ? 16 * nWords : 0));
            totLen_q    <= 7'(eeprom_pkg::HDR_BITS + (cData ? 16 * nWords : 0) + cRx);
            bitCnt_q    <= '0;
            poll_q      <= cPoll;
            polled_q    <= 1'h0;
            rspBusySeen <= 1'h0;
            cs_q        <= 1'h1;
            wPin_q      <= cW; // R7
            prePin_q    <= cPre; // R18
            timer_q     <= 8'(HALF_CYCLES);
            state_q     <= H_SETUP;
          end
        end
        H_SETUP:
          if (timer_q == '0)
          begin
            din_q   <= tx_q[FB-1];
            timer_q <= 8'(HALF_CYCLES);
            state_q <= H_LOW;
          end
        H_LOW:
          if (timer_q == '0)
          begin
            sclk_q  <= 1'h1; // R1
            timer_q <= 8'(HALF_CYCLES);
            state_q <= H_HIGH;
          end
        H_HIGH:
          if (timer_q == '0)
          begin
            sclk_q   <= 1'h0;
            tx_q     <= {tx_q[FB-2:0], 1'h0};
            din_q    <= tx_q[FB-2];
            bitCnt_q <= bitCnt_q + 7'h01;
            timer_q  <= 8'(HALF_CYCLES);
            if (bitCnt_q >= txLen_q - 7'h01) rx_q <= {rx_q[14:0], doutSync_q}; // R18
            state_q  <= (bitCnt_q == totLen_q - 7'h01) ? H_TAIL : H_LOW;
          end
        H_TAIL:
          if (timer_q == '0)
          begin
            cs_q    <= 1'h0; // R8
            din_q   <= 1'h0;
            timer_q <= 8'(GAP_CYCLES);
            state_q <= H_GAP;
          end
        H_GAP:
          if (timer_q == '0)
          begin
            if (poll_q && !polled_q)
            begin
              cs_q     <= 1'h1;
              polled_q <= 1'h1;
              timer_q  <= 8'(HALF_CYCLES);
              state_q  <= H_POLL;
            end else begin
              state_q <= H_DONE;
            end
          end
        H_POLL:
          if (timer_q == '0)
          begin
            if (doutSync_q)
            begin
              cs_q    <= 1'h0;
              timer_q <= 8'(GAP_CYCLES);
              state_q <= H_GAP;
            end else begin
              rspBusySeen <= 1'h1; // R21 R22
            end
          end
        H_DONE:
        begin
          wPin_q   <= 1'h0; // R5
          prePin_q <= 1'h0;
          rspValid <= 1'h1;
          rspData  <= rx_q;
          state_q  <= H_IDLE;
        end
        default: ;
      endcase
    end
  end

  assign link.cs         = cs_q;
  assign link.sclk       = sclk_q;
  assign link.din        = din_q;
  assign link.writeEnPin = wPin_q;
  assign link.protEnPin  = prePin_q;

endmodule : eeprom_host

//--- test/eeprom_link_properties.sv
// Link checker for the joined serial interface
`timescale 1ns/1ps
module eeprom_link_properties #(
  parameter int unsigned PROG_CYCLES = 30
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs,
  input wire logic sclk,
  input wire logic writeEnPin,
  input wire logic dout,
  input wire logic doutEn,
  input wire logic progBusy
);
  int busyCnt_q;
  int sclkHi_q;
  always_ff @(posedge clk_sys)
    busyCnt_q <= (sys_rst || !progBusy) ? 0 : busyCnt_q + 1;
  // Run length of the serial clock high phase
  always_ff @(posedge clk_sys)
    sclkHi_q <= (sys_rst || !sclk) ? 0 : sclkHi_q + 1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_busy; progBusy [*3] ##0 doutEn |-> !dout; endproperty
  a_busy: assert property (p_busy) else $error("busy high");
  property p_ready; $fell(progBusy) ##0 doutEn |-> dout; endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  property p_rel; !cs [*6] |-> !doutEn; endproperty
  a_rel: assert property (p_rel) else $error("driven");
  property p_len;
    $fell(progBusy) |-> busyCnt_q inside {[PROG_CYCLES - 1:PROG_CYCLES + 1]};
  endproperty
  a_len: assert property (p_len) else $error("length");
  property p_csClk; $changed(cs) |-> !sclk; endproperty
  a_csClk: assert property (p_csClk) else $error("select");
  property p_pin; cs && $past(cs) |-> $stable(writeEnPin); endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_gap; $fell(cs) |=> !cs [*4]; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_sclk; $fell(sclk) |-> sclkHi_q >= 10; endproperty
  a_sclk: assert property (p_sclk) else $error("clock");
  cover property (progBusy ##1 !progBusy);
  cover property (doutEn && !dout);
  cover property ($rose(cs) && writeEnPin);
endmodule : eeprom_link_properties

//--- test/test_serial_eeprom_write_protect_ctrl.sv
// Host and device on one link against a reference model
`timescale 1ns/1ps
module test_serial_eeprom_write_protect_ctrl;
  // ****
  // Model and driver
  // ****
  logic             clk_sys = 1'h0, sys_rst = 1'h1, cmdValid = 1'h0;
  eeprom_pkg::cmd_t cmdOp = eeprom_pkg::READ_CMD;
  logic [7:0]       cmdAddr = 8'h00;
  logic [2:0]       cmdWords = 3'h1;
  logic [63:0]      cmdData = 64'h0, d;
  logic [15:0]      rspData, mem [128];
  logic             cmdReady, rspValid, rspBusySeen, progBusy;
  int               failures = 0, checks_done = 0, cycles = 0, ok;
  int               wen = 0, unl = 0, lock = 0, pf = 511;
  eeprom_link_if link();
  eeprom_device #(.PROG_CYCLES(30)) i_eeprom_device(.clk_sys, .sys_rst, .link, .progBusy);
  eeprom_host i_eeprom_host(.clk_sys, .sys_rst, .link, .cmdValid, .cmdOp, .cmdAddr,
    .cmdWords, .cmdData, .cmdReady, .rspValid, .rspData, .rspBusySeen);
  eeprom_link_properties #(.PROG_CYCLES(30)) i_chk(.clk_sys, .sys_rst, .cs(link.cs),
    .sclk(link.sclk), .writeEnPin(link.writeEnPin), .dout(link.dout),
    .doutEn(link.doutEn), .progBusy);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (++cycles == 90000)
      complete_run(1);
  task chk(input logic [15:0] seen, want);
    checks_done++;
    if (seen !== want)
    begin
      failures++;
      $display("[ERR] %0t %h %h", $time, seen, want);
    end
  endtask : chk
  task complete_run(input int extra);
    failures += extra;
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Op numbers follow the order of cmd_t
  task run(input int o, input int a);
    ok = o == 1 ? wen && (pf % 2 || a % 128 < pf / 2 % 128) :
      o == 2 ? wen && (pf % 2 || (a % 128 | 3) < pf / 2 % 128) :
      o == 3 ? wen && pf % 2 : o > 6 && o != 9 ? unl && wen && !lock : -1;
    d = {$urandom, $urandom};
    while (cmdReady !== 1'h1)
      @(negedge clk_sys);
    cmdValid = 1'h1;
    cmdOp = eeprom_pkg::cmd_t'(o);
    cmdAddr = a[7:0];
    cmdWords = o == 2 ? 3'h4 : 3'h1;
    cmdData = d;
    @(negedge clk_sys);
    cmdValid = 1'h0;
    while (rspValid !== 1'h1)
      @(negedge clk_sys);
    if (o == 0)
      chk(rspData, mem[a % 128]);
    if (o == 6)
      chk({6'h00, rspData[9:0]}, 16'(pf));
    if (ok >= 0)
      chk({15'h0000, rspBusySeen}, 16'(ok));
    for (int k = 0; k < 4 && ok == 1 && o == 2; k++)
      mem[a & 124 | a + k & 3] = d[63 - 16 * k -: 16];
    foreach (mem[i])
      if (ok == 1 && (o == 3 || o == 1 && i == a % 128))
        mem[i] = d[63:48];
    pf = ok == 1 && o == 7 ? a * 2 : ok == 1 && o == 8 ? 511 : pf;
    lock = lock || ok == 1 && o == 10;
    wen = o == 4 ? 1 : o == 5 ? 0 : wen;
    unl = o == 9 && wen;
  endtask : run
  initial
  begin
    static int seq[$] = '{1, 5, 0, 5, 4, 192, 1, 22, 0, 150, 2, 22, 0, 20, 0, 21, 0, 22,
      0, 23, 9, 192, 7, 66, 6, 0, 2, 64, 0, 64, 1, 80, 3, 64, 9, 192, 0, 0, 8, 255,
      9, 192, 8, 255, 3, 64, 0, 99, 9, 192, 10, 0, 9, 192, 7, 32, 6, 0, 5, 0, 1, 3, 0, 3};
    foreach (mem[i])
      mem[i] = 16'hFFFF;
    void'($urandom(32'h116E));
    repeat (3)
      @(negedge clk_sys);
    sys_rst = 1'h0;
    for (int i = 0; i < seq.size(); i += 2)
      run(seq[i], seq[i + 1]);
    complete_run(0);
  end
endmodule : test_serial_eeprom_write_protect_ctrl
